/* File: rem_evt_irq.sv */
`timescale 1ns/100ps

module rem_evt_irq (
    input  wire logic                              clk_i,
    input  wire logic                              rst_i,
    input  wire logic                              wb_cyc_i,
    input  wire logic                              wb_stb_i,
    input  wire logic                              wb_we_i,
    input  wire logic [rem_pkg::REM_ADR_W-1:0]     wb_adr_i,
    input  wire logic [rem_pkg::REM_SEL_W-1:0]     wb_sel_i,
    input  wire logic [rem_pkg::REM_DAT_W-1:0]     wb_dat_i,
    output logic      [rem_pkg::REM_DAT_W-1:0]     wb_dat_o,
    output logic                                   wb_ack_o,
    input  wire logic [rem_pkg::REM_NUM_CFG-1:0]   evt_wake_i,
    input  wire logic [rem_pkg::REM_NUM_CFG-1:0]   evt_frame_lock_i,
    input  wire logic [rem_pkg::REM_NUM_CFG-1:0]   evt_id_found_i,
    input  wire logic [rem_pkg::REM_NUM_CFG-1:0]   evt_msg_end_i,
    output logic                                   irq_o
);
    import rem_pkg::*;

    // ==========================================================
    // Bus handshake
    logic take;
    logic commit_wr;

    rem_wb_slave u_slave (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .wb_cyc_i    (wb_cyc_i),
        .wb_stb_i    (wb_stb_i),
        .wb_we_i     (wb_we_i),
        .wb_ack_o    (wb_ack_o),
        .take_o      (take),
        .commit_wr_o (commit_wr)
    );

    // ==========================================================
    // Address decode
    wire hit_mask_ab = (wb_adr_i == REM_ADDR_MASK_AB);
    wire hit_mask_cd = (wb_adr_i == REM_ADDR_MASK_CD);
    wire hit_status  = (wb_adr_i == REM_ADDR_STATUS);
    wire hit_clear   = (wb_adr_i == REM_ADDR_CLEAR);
    wire hit_enable  = (wb_adr_i == REM_ADDR_ENABLE);

    wire wr_mask_ab = commit_wr && hit_mask_ab && wb_sel_i[0];
    wire wr_mask_cd = commit_wr && hit_mask_cd && wb_sel_i[0];
    wire wr_en_lo   = commit_wr && hit_enable && wb_sel_i[0];
    wire wr_en_hi   = commit_wr && hit_enable && wb_sel_i[1];
    wire wr_clr_lo  = commit_wr && hit_clear && wb_sel_i[0];
    wire wr_clr_hi  = commit_wr && hit_clear && wb_sel_i[1];

    // ==========================================================
    // Mask registers, one nibble per configuration
    logic [REM_MASK_W-1:0] mask_ab_q;
    logic [REM_MASK_W-1:0] mask_ab_d;
    logic [REM_MASK_W-1:0] mask_cd_q;
    logic [REM_MASK_W-1:0] mask_cd_d;

    assign mask_ab_d = wr_mask_ab ? wb_dat_i[REM_MASK_W-1:0] : mask_ab_q;
    assign mask_cd_d = wr_mask_cd ? wb_dat_i[REM_MASK_W-1:0] : mask_cd_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_ab_q <= REM_MASK_RST;
            mask_cd_q <= REM_MASK_RST;
        end else begin
            mask_ab_q <= mask_ab_d;
            mask_cd_q <= mask_cd_d;
        end
    end

    // Bit index is configuration * 4 + event
    logic [REM_NUM_SRC-1:0] mask_all;
    assign mask_all = {mask_cd_q, mask_ab_q};

    // ==========================================================
    // Event vector in mask layout
    logic [REM_NUM_SRC-1:0] evt_all;

    genvar c;
    generate
        for (c = 0; c < REM_NUM_CFG; c++) begin : g_cfg
            assign evt_all[c*REM_NUM_EV + REM_EV_WAKE]  = evt_wake_i[c];
            assign evt_all[c*REM_NUM_EV + REM_EV_FRAME] = evt_frame_lock_i[c];
            assign evt_all[c*REM_NUM_EV + REM_EV_ID]    = evt_id_found_i[c];
            assign evt_all[c*REM_NUM_EV + REM_EV_END]   = evt_msg_end_i[c];
        end
    endgenerate

    // ==========================================================
    // Enable and clear registers
    logic [REM_NUM_SRC-1:0] enable_q;
    logic [REM_NUM_SRC-1:0] enable_d;
    logic [REM_NUM_SRC-1:0] clr_vec;
    logic [REM_NUM_SRC-1:0] status;

    assign enable_d[7:0]  = wr_en_lo ? wb_dat_i[7:0] : enable_q[7:0];
    assign enable_d[15:8] = wr_en_hi ? wb_dat_i[15:8] : enable_q[15:8];
    assign clr_vec[7:0]   = wr_clr_lo ? wb_dat_i[7:0] : 8'h00;
    assign clr_vec[15:8]  = wr_clr_hi ? wb_dat_i[15:8] : 8'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_q <= REM_ENABLE_RST;
        end else begin
            enable_q <= enable_d;
        end
    end

    // ==========================================================
    // Sticky status, only unmasked events land here
    rem_evt_gate #(
        .N (REM_NUM_SRC)
    ) u_gate (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .evt_i    (evt_all),
        .mask_i   (mask_all),
        .clr_i    (clr_vec),
        .status_o (status)
    );

    // ==========================================================
    // Interrupt output
    assign irq_o = |(status & enable_q);

    // ==========================================================
    // Read data, masks and clear read as zero
    logic [REM_DAT_W-1:0] rd_word;
    logic [REM_DAT_W-1:0] rd_q;

    assign rd_word = hit_status ? {{(REM_DAT_W-REM_NUM_SRC){1'b0}}, status}
                   : hit_enable ? {{(REM_DAT_W-REM_NUM_SRC){1'b0}}, enable_q}
                   : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_q <= '0;
        end else if (take) begin
            rd_q <= rd_word;
        end
    end

    assign wb_dat_o = rd_q;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_masked_no_set;
        1'b1 |=> ((status & ~$past(status) & $past(mask_all)) == '0);
    endproperty
    a_masked_no_set: assert property (p_masked_no_set)
        else $error("masked event set a status flag");

    property p_unmasked_sets;
        ((evt_all & ~mask_all) != '0) |=> ((status & $past(evt_all & ~mask_all)) == $past(evt_all & ~mask_all));
    endproperty
    a_unmasked_sets: assert property (p_unmasked_sets)
        else $error("unmasked event did not set its status flag");

    property p_mask_ab_write;
        wr_mask_ab |=> (mask_ab_q == $past(wb_dat_i[7:0]));
    endproperty
    a_mask_ab_write: assert property (p_mask_ab_write)
        else $error("mask register for configurations A and B not written");

    property p_mask_cd_write;
        wr_mask_cd |=> (mask_cd_q == $past(wb_dat_i[7:0]));
    endproperty
    a_mask_cd_write: assert property (p_mask_cd_write)
        else $error("mask register for configurations C and D not written");

    property p_reset_clears;
        $fell(rst_i) |-> (mask_ab_q == 8'h00 && mask_cd_q == 8'h00);
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("mask bits not cleared by reset");

    property p_cfg_independent;
        (wr_mask_ab && !wr_mask_cd) |=> $stable(mask_cd_q);
    endproperty
    a_cfg_independent: assert property (p_cfg_independent)
        else $error("write to one mask register disturbed the other");

    property p_frame_a_slot;
        (evt_frame_lock_i[REM_CFG_A] && !mask_ab_q[REM_EV_FRAME]) |=> status[REM_EV_FRAME];
    endproperty
    a_frame_a_slot: assert property (p_frame_a_slot)
        else $error("frame lock of configuration A mapped to wrong bit");

    property p_irq_follows;
        ((evt_all & ~mask_all & enable_d) != '0) |=> irq_o;
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("unmasked enabled event did not raise interrupt");

    property p_irq_quiet;
        (!irq_o && ((evt_all & ~mask_all) == '0) && !wr_en_lo && !wr_en_hi) |=> !irq_o;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("interrupt rose without an unmasked event");

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held longer than one cycle");

    property p_ack_next;
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("request not acknowledged in the next cycle");

    // ==========================================================
    // Slot mapping, hold and status checks
    property p_mask_ab_hold;
        !wr_mask_ab |=> $stable(mask_ab_q);
    endproperty
    a_mask_ab_hold: assert property (p_mask_ab_hold)
        else $error("mask register for configurations A and B changed without a write");

    property p_mask_cd_hold;
        !wr_mask_cd |=> $stable(mask_cd_q);
    endproperty
    a_mask_cd_hold: assert property (p_mask_cd_hold)
        else $error("mask register for configurations C and D changed without a write");

    property p_wake_b_slot;
        (evt_wake_i[REM_CFG_B] && !mask_ab_q[REM_NUM_EV + REM_EV_WAKE]) |=> status[REM_CFG_B*REM_NUM_EV + REM_EV_WAKE];
    endproperty
    a_wake_b_slot: assert property (p_wake_b_slot)
        else $error("wake-up of configuration B mapped to wrong bit");

    property p_id_c_slot;
        (evt_id_found_i[REM_CFG_C] && !mask_cd_q[REM_EV_ID]) |=> status[REM_CFG_C*REM_NUM_EV + REM_EV_ID];
    endproperty
    a_id_c_slot: assert property (p_id_c_slot)
        else $error("id found of configuration C mapped to wrong bit");

    property p_end_d_slot;
        (evt_msg_end_i[REM_CFG_D] && !mask_cd_q[REM_NUM_EV + REM_EV_END]) |=> status[REM_CFG_D*REM_NUM_EV + REM_EV_END];
    endproperty
    a_end_d_slot: assert property (p_end_d_slot)
        else $error("message end of configuration D mapped to wrong bit");

    property p_masked_wake_a;
        (evt_wake_i[REM_CFG_A] && mask_ab_q[REM_EV_WAKE] && !status[REM_EV_WAKE]) |=> !status[REM_EV_WAKE];
    endproperty
    a_masked_wake_a: assert property (p_masked_wake_a)
        else $error("masked wake-up of configuration A set its flag");

    property p_status_sticky;
        1'b1 |=> (($past(status) & ~$past(clr_vec) & ~status) == '0);
    endproperty
    a_status_sticky: assert property (p_status_sticky)
        else $error("status flag dropped without a clear");

    property p_clear_drops;
        1'b1 |=> ((status & $past(clr_vec) & ~$past(evt_all & ~mask_all)) == '0);
    endproperty
    a_clear_drops: assert property (p_clear_drops)
        else $error("cleared status flag stayed set");

    property p_mask_read_zero;
        (take && !wb_we_i && (hit_mask_ab || hit_mask_cd)) |=> (wb_dat_o == '0);
    endproperty
    a_mask_read_zero: assert property (p_mask_read_zero)
        else $error("write-only mask register read nonzero");

    property p_ack_needs_req;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_needs_req: assert property (p_ack_needs_req)
        else $error("ack without a request");

    property p_reset_enables;
        $fell(rst_i) |-> (!irq_o && (enable_q == REM_ENABLE_RST));
    endproperty
    a_reset_enables: assert property (p_reset_enables)
        else $error("reset left interrupt or enable in wrong state");

    c_irq_raised: cover property (!irq_o ##1 irq_o);
    c_masked_evt: cover property ((evt_all & mask_all) != '0);
    c_clear_flag: cover property ((clr_vec & status) != '0);
    c_mask_write: cover property (wr_mask_cd);
    c_frame_d:    cover property (evt_frame_lock_i[REM_CFG_D] && !mask_cd_q[REM_NUM_EV + REM_EV_FRAME]);

endmodule

/* File: rem_pkg.sv */
package rem_pkg;

    // ==========================================================
    // Bus geometry
    localparam int REM_ADR_W = 12;
    localparam int REM_DAT_W = 32;
    localparam int REM_SEL_W = 4;
    localparam int REM_IDX_W = 10;

    // ==========================================================
    // Register indices and byte addresses (byte address = 4 * index)
    localparam logic [REM_IDX_W-1:0] REM_IDX_MASK_AB = 10'h094;
    localparam logic [REM_IDX_W-1:0] REM_IDX_MASK_CD = 10'h095;
    localparam logic [REM_IDX_W-1:0] REM_IDX_STATUS  = 10'h0A0;
    localparam logic [REM_IDX_W-1:0] REM_IDX_CLEAR   = 10'h0A1;
    localparam logic [REM_IDX_W-1:0] REM_IDX_ENABLE  = 10'h0A2;

    localparam logic [REM_ADR_W-1:0] REM_ADDR_MASK_AB = {REM_IDX_MASK_AB, 2'b00};
    localparam logic [REM_ADR_W-1:0] REM_ADDR_MASK_CD = {REM_IDX_MASK_CD, 2'b00};
    localparam logic [REM_ADR_W-1:0] REM_ADDR_STATUS  = {REM_IDX_STATUS, 2'b00};
    localparam logic [REM_ADR_W-1:0] REM_ADDR_CLEAR   = {REM_IDX_CLEAR, 2'b00};
    localparam logic [REM_ADR_W-1:0] REM_ADDR_ENABLE  = {REM_IDX_ENABLE, 2'b00};

    // ==========================================================
    // Event layout: nibble per configuration, event order inside nibble
    localparam int REM_NUM_CFG = 4;
    localparam int REM_NUM_EV  = 4;
    localparam int REM_NUM_SRC = REM_NUM_CFG * REM_NUM_EV;
    localparam int REM_MASK_W  = 8;

    localparam int REM_EV_WAKE  = 0;
    localparam int REM_EV_FRAME = 1;
    localparam int REM_EV_ID    = 2;
    localparam int REM_EV_END   = 3;

    localparam int REM_CFG_A = 0;
    localparam int REM_CFG_B = 1;
    localparam int REM_CFG_C = 2;
    localparam int REM_CFG_D = 3;

    // ==========================================================
    // Reset values
    localparam logic [REM_MASK_W-1:0]  REM_MASK_RST   = 8'h00;
    localparam logic [REM_NUM_SRC-1:0] REM_ENABLE_RST = 16'hFFFF;
    localparam logic [REM_NUM_SRC-1:0] REM_STATUS_RST = 16'h0000;

endpackage

/* File: rem_wb_slave.sv */
`timescale 1ns/100ps

module rem_wb_slave (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic wb_cyc_i,
    input  wire logic wb_stb_i,
    input  wire logic wb_we_i,
    output logic      wb_ack_o,
    output logic      take_o,
    output logic      commit_wr_o
);
    import rem_pkg::*;

    // ==========================================================
    // Classic single cycle handshake, one wait state
    logic ack_q;
    logic ack_d;
    wire  req = wb_cyc_i && wb_stb_i;

    assign ack_d       = req && !ack_q;
    assign take_o      = req && !ack_q;
    assign commit_wr_o = req && ack_q && wb_we_i;
    assign wb_ack_o    = ack_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

endmodule

/* File: rem_evt_gate.sv */
`timescale 1ns/100ps

module rem_evt_gate #(
    parameter int N = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [N-1:0] evt_i,
    input  wire logic [N-1:0] mask_i,
    input  wire logic [N-1:0] clr_i,
    output logic      [N-1:0] status_o
);
    import rem_pkg::*;

    // ==========================================================
    // Sticky flag per source, set beats clear
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_src
            logic flag_q;
            logic flag_d;
            logic set;
            assign set    = evt_i[g] && !mask_i[g];
            assign flag_d = set || (flag_q && !clr_i[g]);
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    flag_q <= REM_STATUS_RST[g];
                end else begin
                    flag_q <= flag_d;
                end
            end
            assign status_o[g] = flag_q;
        end
    endgenerate

endmodule

/* File: rem_host.sv */
`timescale 1ns/100ps

// ==========================================
// Host side bus master
module rem_host (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [11:0]      adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 12'h000;
        sel_o = 4'h0;
        dat_o = 32'h0000_0000;
    end

    // ==========================================
    // Single classic cycle, entered right after an edge
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        sel_o <= 4'h3;
        dat_o <= d;
        @(posedge clk_i);
        while (ack_i !== 1'b1) begin
            @(posedge clk_i);
        end
        // Released address and data lines carry junk, not the last value
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o  <= 1'b0;
        adr_o <= ~a;
        dat_o <= ~d;
        @(posedge clk_i);
    endtask
endmodule

/* File: tb.sv */
`timescale 1ns/100ps

module tb;
    import rem_pkg::*;
    typedef struct {string nm; logic [32:0] v;} rem_exp_t;
    logic        clk_i, rst_i, cyc, stb, we, ack, irq;
    logic [11:0] adr;
    logic [3:0]  sel, ev_wake, ev_frame, ev_id, ev_end;
    logic [31:0] wdat, rdat;
    rem_exp_t    exp_q[$];
    rem_exp_t    e;
    int          bad_count, n_checks, i;
    int          seed = 32'hde9e;
    logic [15:0] m, v, x;

    rem_evt_irq u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .evt_wake_i(ev_wake), .evt_frame_lock_i(ev_frame),
        .evt_id_found_i(ev_id), .evt_msg_end_i(ev_end), .irq_o(irq));
    rem_host u_host (.clk_i(clk_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we),
        .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    // ==========================================
    // Clock and watchdog
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        final_report;
    end

    // ==========================================
    // Monitor: read acks against oldest note
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            n_checks++;
            if ({irq, rdat} !== e.v) begin
                bad_count++;
                $display("wrong value %s expected %h seen %h", e.nm, e.v, {irq, rdat});
            end
        end
    end

    // ==========================================
    // Helpers
    task automatic rd(input string nm, input logic [11:0] a, input logic q, input logic [15:0] d);
        exp_q.push_back('{nm, {q, 16'h0000, d}});
        u_host.xfer(a, 1'b0, 32'h0000_0000);
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        u_host.xfer(a, 1'b1, {16'h0000, d});
    endtask
    task automatic fire(input logic [15:0] f);
        logic [3:0] w, fl, idf, en;
        for (int c = 0; c < 4; c++) begin
            w[c]   = f[c*4+REM_EV_WAKE];
            fl[c]  = f[c*4+REM_EV_FRAME];
            idf[c] = f[c*4+REM_EV_ID];
            en[c]  = f[c*4+REM_EV_END];
        end
        ev_wake  <= w;
        ev_frame <= fl;
        ev_id    <= idf;
        ev_end   <= en;
        @(posedge clk_i);
        {ev_wake, ev_frame, ev_id, ev_end} <= 16'h0000;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic final_report;
        if (exp_q.size() != 0)
            bad_count++;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        rst_i = 1'b1;
        {ev_wake, ev_frame, ev_id, ev_end} = 16'h0000;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd("status after reset", REM_ADDR_STATUS, 1'b0, 16'h0000);
        for (i = 0; i < 16; i++) begin
            fire(16'h0001 << i);
            rd("single event", REM_ADDR_STATUS, 1'b1, 16'h0001 << i);
            wr(REM_ADDR_CLEAR, 16'hFFFF);
        end
        rd("mask ab readback", REM_ADDR_MASK_AB, 1'b0, 16'h0000);
        rd("unmapped", 12'h3FC, 1'b0, 16'h0000);
        $display("test reset done, mismatches %0d", bad_count);
        for (i = 0; i < 24; i++) begin
            m = 16'($random(seed));
            v = 16'($random(seed));
            if (i == 0)
                m = 16'h00FF;
            if (i == 1)
                m = 16'hFF00;
            wr(REM_ADDR_MASK_AB, {8'h00, m[7:0]});
            wr(REM_ADDR_MASK_CD, {8'h00, m[15:8]});
            fire(v);
            x = v & ~m;
            rd("masked status", REM_ADDR_STATUS, |x, x);
            wr(REM_ADDR_CLEAR, 16'hFFFF);
        end
        $display("test random mask done, mismatches %0d", bad_count);
        wr(REM_ADDR_MASK_AB, 16'h0000);
        wr(REM_ADDR_MASK_CD, 16'h0000);
        wr(REM_ADDR_ENABLE, 16'h0000);
        fire(16'hFFFF);
        rd("disabled status", REM_ADDR_STATUS, 1'b0, 16'hFFFF);
        wr(REM_ADDR_ENABLE, 16'h0010);
        rd("enabled status", REM_ADDR_STATUS, 1'b1, 16'hFFFF);
        wr(REM_ADDR_CLEAR, 16'h0010);
        rd("cleared status", REM_ADDR_STATUS, 1'b0, 16'hFFEF);
        wr(REM_ADDR_MASK_AB, 16'h0010);
        wr(REM_ADDR_ENABLE, 16'hFFFF);
        wr(REM_ADDR_CLEAR, 16'hFFFF);
        fire(16'h0010);
        rd("masked wake b", REM_ADDR_STATUS, 1'b0, 16'h0000);
        $display("test enable done, mismatches %0d", bad_count);
        wr(REM_ADDR_MASK_CD, 16'h00FF);
        wr(REM_ADDR_ENABLE, 16'h0000);
        fire(16'h00FF);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd("status after mid reset", REM_ADDR_STATUS, 1'b0, 16'h0000);
        rd("enable after mid reset", REM_ADDR_ENABLE, 1'b0, 16'hFFFF);
        fire(16'hFFFF);
        rd("unmasked after mid reset", REM_ADDR_STATUS, 1'b1, 16'hFFFF);
        $display("test mid reset done, mismatches %0d", bad_count);
        final_report;
    end
endmodule
